// [rtl/ixbcs_pkg.sv]
/*
  Shared constants and types for the indexed-X bus-cycle sequencer:
  opcode values, fixed bus addresses, instruction groups and bus steps.
  Assumes a single CPU bus clock; no timing figures live here.
*/
// Functional notes
// RL1 - extended word compare: seven read cycles
// RL2 - extended call: six cycles, reads target opcode
// RL3 - call pushes return low, then high, writing
// RL4 - indexed: opcode, offset, dummy read at FFFF
// RL5 - indexed jump: three cycles, no operand access
// RL6 - indexed byte group: four cycles, operand last
// RL7 - read-modify-write: read, dummy, write back
// RL8 - indexed test: read, two dummies, no write
// RL9 - word loads: five cycles, high then low
// RL10 - load Y: prefixed, six cycles
// RL11 - word stores: five cycles, high then low
// RL12 - store Y: prefixed, writes cycles five, six
// RL13 - word arithmetic: two reads plus dummy
// RL14 - word compares D/Y: prefixed, seven cycles
// RL15 - indexed call: six cycles, target read fourth
// RL16 - bit set/clear: seven cycles, mask at +2
// RL17 - branch on bits: seven reads, mask, offset
// RL18 - address is X plus unsigned offset, wrapping
package ixbcs_pkg;

  // fixed bus addresses and step sizes
  localparam logic [15:0] DUMMY_ADDR = 16'hFFFF;
  localparam logic [15:0] IDLE_ADDR = 16'hFFFF;
  localparam logic [15:0] ONE_WORD = 16'h0001;
  localparam logic [2:0] ONE_CYCLE = 3'h1;

  // first opcode bytes
  localparam logic [7:0] OPC_PAGE_A = 8'h1A;
  localparam logic [7:0] OPC_PAGE_B = 8'h18;
  localparam logic [7:0] OPC_JUMP_X = 8'h6E;
  localparam logic [7:0] OPC_TEST_X = 8'h6D;
  localparam logic [7:0] OPC_CALL_X = 8'hAD;
  localparam logic [7:0] OPC_CALL_EXT = 8'hBD;
  localparam logic [7:0] OPC_SUB_D_WORD_X = 8'hA3;
  localparam logic [7:0] OPC_ADD_D_WORD_X = 8'hE3;
  localparam logic [7:0] OPC_CMP_X_WORD_X = 8'hAC;
  localparam logic [7:0] OPC_STORE_ONE_X = 8'hA7;
  localparam logic [7:0] OPC_STORE_TWO_X = 8'hE7;
  localparam logic [7:0] OPC_LOAD_D_WORD_X = 8'hEC;
  localparam logic [7:0] OPC_STORE_D_WORD_X = 8'hED;
  localparam logic [7:0] OPC_LOAD_S_WORD_X = 8'hAE;
  localparam logic [7:0] OPC_STORE_S_WORD_X = 8'hAF;
  localparam logic [7:0] OPC_LOAD_X_WORD_X = 8'hEE;
  localparam logic [7:0] OPC_STORE_X_WORD_X = 8'hEF;
  localparam logic [7:0] OPC_BIT_SET_X = 8'h1C;
  localparam logic [7:0] OPC_BIT_CLEAR_X = 8'h1D;
  localparam logic [7:0] OPC_BRANCH_SET_X = 8'h1E;
  localparam logic [7:0] OPC_BRANCH_CLEAR_X = 8'h1F;

  // opcode ranges by high nibble
  localparam logic [3:0] NIB_MODIFY_X = 4'h6;
  localparam logic [3:0] NIB_BYTE_A_X = 4'hA;
  localparam logic [3:0] NIB_BYTE_B_X = 4'hE;

  // second bytes after a prefix
  localparam logic [7:0] OPC2_LOAD_Y_X = 8'hEE;
  localparam logic [7:0] OPC2_STORE_Y_X = 8'hEF;
  localparam logic [7:0] OPC2_CMP_D_X = 8'hA3;
  localparam logic [7:0] OPC2_CMP_Y_X = 8'hAC;
  localparam logic [7:0] OPC2_CMP_D_EXT = 8'hB3;
  localparam logic [7:0] OPC2_CMP_Y_EXT = 8'hBC;

  // instruction groups, each with its own bus pattern
  typedef enum logic [3:0] {
    G_NONE, G_JUMP, G_BYTE, G_STORE8, G_MODIFY, G_TEST, G_LOAD16,
    G_STORE16, G_WORD_ARITH, G_CALL_X, G_BIT_MEM, G_BRANCH_BITS,
    G_EXT_CMP, G_EXT_CALL
  } ixbcs_group_t;

  // bus steps; the step names the meaning of the data byte
  typedef enum logic [4:0] {
    ST_IDLE, ST_OPCODE, ST_PAGE2, ST_OFFSET, ST_EXT_HI, ST_EXT_LO,
    ST_DUMMY, ST_OPND, ST_OPND_LO, ST_MASK, ST_BROFF, ST_DUMMY2,
    ST_DUMMY3, ST_WRITE, ST_WRITE_LO, ST_TARGET, ST_PUSH_LO, ST_PUSH_HI
  } ixbcs_step_t;

endpackage

// [rtl/ixbcs_ea_adder.sv]
/*
  Effective-address adder for indexed addressing.
  Purely combinational; the caller holds base and offset stable.
*/
`timescale 1ns/1ns
module ixbcs_ea_adder (
  // operands
  input wire logic [15:0] base,
  input wire logic [7:0] offset,
  // result
  output logic [15:0] sum
);

  // offset is unsigned; the carry out of bit 15 is dropped on purpose
  assign sum = base + {8'h00, offset}; // RL18

endmodule

// [rtl/ixbcs_sequencer.sv]
/*
  Bus-cycle sequencer for indexed-X instructions plus the extended
  word compares and the extended call. Fetches, decodes the opcode,
  and drives address, read/write and write data one cycle per step.
  Assumes memory on the same clock answers a read within the cycle,
  and that the core supplies index, stack and store data at START
  and the modify result while the second dummy read is on the bus.
*/
`timescale 1ns/1ns
module ixbcs_sequencer
  import ixbcs_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // instruction start from the core
  input wire logic START,
  input wire logic [15:0] PC_IN,
  input wire logic [15:0] X_IN,
  input wire logic [15:0] SP_IN,
  input wire logic [15:0] STORE_WORD,
  input wire logic [7:0] STORE_BYTE,
  input wire logic [7:0] RESULT_BYTE,
  // memory bus
  output logic [15:0] ADDR,
  output logic RW,
  output logic [7:0] DATA_OUT,
  input wire logic [7:0] DATA_IN,
  // sequencing status
  output logic BUSY,
  output logic DONE,
  output logic ILLEGAL,
  output ixbcs_step_t STEP,
  output ixbcs_group_t GROUP,
  output logic [2:0] CYCLE_NUM,
  // captured bytes for the core
  output logic [7:0] OPCODE,
  output logic [7:0] PAGE_OPCODE,
  output logic [15:0] OPERAND_WORD,
  output logic [7:0] MASK_BYTE,
  output logic [7:0] BRANCH_BYTE,
  output logic [7:0] TARGET_OPCODE,
  output logic [15:0] TARGET_ADDR,
  output logic [15:0] NEXT_PC
);

  // sequencing state
  ixbcs_step_t step, next_step;
  ixbcs_group_t group, next_group;
  logic [15:0] addr, next_addr;
  logic rw, next_rw;
  logic [7:0] dout, next_dout;
  logic [2:0] cycle, next_cycle;
  logic [15:0] fetch, next_fetch;
  logic [15:0] eff, next_eff;
  logic [7:0] offset, next_offset;
  logic [15:0] x_base, next_x_base;
  logic [15:0] sp, next_sp;
  logic [15:0] store_word, next_store_word;
  logic [7:0] store_byte, next_store_byte;
  logic [7:0] opcode, next_opcode;
  logic [7:0] page, next_page;
  logic [15:0] operand, next_operand;
  logic [7:0] mask, next_mask;
  logic [7:0] branch, next_branch;
  logic [7:0] target_opc, next_target_opc;
  logic [15:0] target, next_target;
  logic [15:0] ea_sum;
  logic done, illegal;

  // index plus offset, shared by every indexed group
  ixbcs_ea_adder u_ea (
    .base(x_base),
    .offset(offset),
    .sum(ea_sum)
  );

  // single-byte opcode decode; undefined codes in the modify
  // column are treated as modify, which keeps the decode small
  function automatic ixbcs_group_t decode_first(input logic [7:0] op);
    ixbcs_group_t g;
    g = G_NONE;
    case (op)
      OPC_JUMP_X: g = G_JUMP; // RL5
      OPC_TEST_X: g = G_TEST; // RL8
      OPC_CALL_X: g = G_CALL_X; // RL15
      OPC_CALL_EXT: g = G_EXT_CALL; // RL2
      OPC_SUB_D_WORD_X, OPC_ADD_D_WORD_X, OPC_CMP_X_WORD_X:
        g = G_WORD_ARITH; // RL13
      OPC_STORE_ONE_X, OPC_STORE_TWO_X: g = G_STORE8;
      OPC_LOAD_D_WORD_X, OPC_LOAD_S_WORD_X, OPC_LOAD_X_WORD_X:
        g = G_LOAD16; // RL9
      OPC_STORE_D_WORD_X, OPC_STORE_S_WORD_X, OPC_STORE_X_WORD_X:
        g = G_STORE16; // RL11
      OPC_BIT_SET_X, OPC_BIT_CLEAR_X: g = G_BIT_MEM; // RL16
      OPC_BRANCH_SET_X, OPC_BRANCH_CLEAR_X: g = G_BRANCH_BITS; // RL17
      default: begin
        if (op[7:4] == NIB_MODIFY_X) begin
          g = G_MODIFY; // RL7
        end else if (op[7:4] == NIB_BYTE_A_X || op[7:4] == NIB_BYTE_B_X) begin
          g = G_BYTE; // RL6
        end
      end
    endcase
    return g;
  endfunction

  // second-byte decode behind a prefix
  function automatic ixbcs_group_t decode_second(input logic [7:0] pre,
                                                input logic [7:0] op);
    ixbcs_group_t g;
    g = G_NONE;
    if (pre == OPC_PAGE_A) begin
      case (op)
        OPC2_CMP_D_X, OPC2_CMP_Y_X: g = G_WORD_ARITH; // RL14
        OPC2_LOAD_Y_X: g = G_LOAD16; // RL10
        OPC2_STORE_Y_X: g = G_STORE16; // RL12
        OPC2_CMP_D_EXT: g = G_EXT_CMP; // RL1
        default: g = G_NONE;
      endcase
    end else if (op == OPC2_CMP_Y_EXT) begin
      g = G_EXT_CMP; // RL1
    end
    return g;
  endfunction

  // next bus cycle: one step per clock, address and level
  // are decided here so the pins come straight from flops
  always_comb begin
    next_step = step;
    next_group = group;
    next_addr = addr;
    next_rw = 1'b1;
    next_dout = dout;
    next_cycle = cycle + ONE_CYCLE;
    next_fetch = fetch;
    next_eff = eff;
    next_offset = offset;
    next_x_base = x_base;
    next_sp = sp;
    next_store_word = store_word;
    next_store_byte = store_byte;
    next_opcode = opcode;
    next_page = page;
    next_operand = operand;
    next_mask = mask;
    next_branch = branch;
    next_target_opc = target_opc;
    next_target = target;
    done = 1'b0;
    illegal = 1'b0;
    case (step)
      ST_IDLE: begin
        next_cycle = cycle;
        if (START) begin
          // core state is caught once so it cannot move mid-instruction
          next_step = ST_OPCODE;
          next_addr = PC_IN;
          next_fetch = PC_IN;
          next_x_base = X_IN;
          next_sp = SP_IN;
          next_store_word = STORE_WORD;
          next_store_byte = STORE_BYTE;
          next_operand = 16'h0000;
          next_page = 8'h00;
          next_cycle = ONE_CYCLE;
        end
      end
      ST_OPCODE: begin
        next_opcode = DATA_IN;
        next_fetch = fetch + ONE_WORD;
        next_addr = fetch + ONE_WORD;
        next_group = decode_first(DATA_IN);
        if (DATA_IN == OPC_PAGE_A || DATA_IN == OPC_PAGE_B) begin
          next_step = ST_PAGE2;
        end else if (decode_first(DATA_IN) == G_EXT_CALL) begin
          next_step = ST_EXT_HI; // RL2
        end else if (decode_first(DATA_IN) != G_NONE) begin
          next_step = ST_OFFSET; // RL4
        end else begin
          illegal = 1'b1;
        end
      end
      ST_PAGE2: begin
        next_page = DATA_IN;
        next_fetch = fetch + ONE_WORD;
        next_addr = fetch + ONE_WORD;
        next_group = decode_second(opcode, DATA_IN);
        if (decode_second(opcode, DATA_IN) == G_EXT_CMP) begin
          next_step = ST_EXT_HI; // RL1
        end else if (decode_second(opcode, DATA_IN) != G_NONE) begin
          next_step = ST_OFFSET; // RL14
        end else begin
          illegal = 1'b1;
        end
      end
      ST_OFFSET: begin
        next_offset = DATA_IN;
        next_fetch = fetch + ONE_WORD;
        next_step = ST_DUMMY;
        next_addr = DUMMY_ADDR; // RL4
      end
      ST_DUMMY: begin
        next_eff = ea_sum; // RL18
        next_addr = ea_sum;
        case (group)
          G_JUMP: begin
            next_target = ea_sum; // RL5
            next_step = ST_IDLE;
          end
          G_STORE8: begin
            next_step = ST_WRITE;
            next_rw = 1'b0;
            next_dout = store_byte;
          end
          G_STORE16: begin
            next_step = ST_WRITE;
            next_rw = 1'b0; // RL11
            next_dout = store_word[15:8]; // RL12
          end
          G_CALL_X: next_step = ST_TARGET; // RL15
          default: next_step = ST_OPND; // RL6
        endcase
      end
      ST_EXT_HI: begin
        next_eff = {DATA_IN, eff[7:0]};
        next_fetch = fetch + ONE_WORD;
        next_addr = fetch + ONE_WORD;
        next_step = ST_EXT_LO;
      end
      ST_EXT_LO: begin
        next_eff = {eff[15:8], DATA_IN};
        next_addr = {eff[15:8], DATA_IN};
        next_fetch = fetch + ONE_WORD;
        if (group == G_EXT_CALL) begin
          next_step = ST_TARGET; // RL2
        end else begin
          next_step = ST_OPND; // RL1
        end
      end
      ST_OPND: begin
        // shift in so word operands land high byte first
        next_operand = {operand[7:0], DATA_IN};
        case (group)
          G_BYTE: next_step = ST_IDLE; // RL6
          G_MODIFY, G_TEST: begin
            next_step = ST_DUMMY2;
            next_addr = DUMMY_ADDR; // RL7
          end
          G_BIT_MEM, G_BRANCH_BITS: begin
            next_step = ST_MASK;
            next_addr = fetch; // RL16
          end
          default: begin
            next_step = ST_OPND_LO;
            next_addr = addr + ONE_WORD; // RL9
          end
        endcase
      end
      ST_OPND_LO: begin
        next_operand = {operand[7:0], DATA_IN};
        if (group == G_LOAD16) begin
          next_step = ST_IDLE; // RL10
        end else begin
          next_step = ST_DUMMY2;
          next_addr = DUMMY_ADDR; // RL13
        end
      end
      ST_MASK: begin
        next_mask = DATA_IN;
        next_fetch = fetch + ONE_WORD;
        if (group == G_BIT_MEM) begin
          next_step = ST_DUMMY2;
          next_addr = DUMMY_ADDR; // RL16
        end else begin
          next_step = ST_BROFF;
          next_addr = fetch + ONE_WORD; // RL17
        end
      end
      ST_BROFF: begin
        next_branch = DATA_IN;
        next_fetch = fetch + ONE_WORD;
        next_step = ST_DUMMY2;
        next_addr = DUMMY_ADDR; // RL17
      end
      ST_DUMMY2: begin
        case (group)
          G_MODIFY, G_BIT_MEM: begin
            // result is taken late so the core's ALU has a full cycle
            next_step = ST_WRITE;
            next_addr = eff;
            next_rw = 1'b0; // RL7
            next_dout = RESULT_BYTE;
          end
          G_TEST: begin
            next_step = ST_DUMMY3;
            next_addr = DUMMY_ADDR; // RL8
          end
          default: next_step = ST_IDLE; // RL13
        endcase
      end
      ST_DUMMY3: next_step = ST_IDLE; // RL8
      ST_WRITE: begin
        if (group == G_STORE16) begin
          next_step = ST_WRITE_LO;
          next_addr = addr + ONE_WORD;
          next_rw = 1'b0; // RL11
          next_dout = store_word[7:0]; // RL12
        end else begin
          next_step = ST_IDLE;
        end
      end
      ST_WRITE_LO: next_step = ST_IDLE;
      ST_TARGET: begin
        next_target_opc = DATA_IN;
        next_target = eff;
        next_step = ST_PUSH_LO;
        next_addr = sp;
        next_rw = 1'b0; // RL3
        next_dout = fetch[7:0];
      end
      ST_PUSH_LO: begin
        next_step = ST_PUSH_HI;
        next_addr = sp - ONE_WORD;
        next_rw = 1'b0; // RL3
        next_dout = fetch[15:8];
      end
      ST_PUSH_HI: next_step = ST_IDLE; // RL3
      default: next_step = ST_IDLE;
    endcase
    // any finishing step parks the bus reading the idle address
    if (step != ST_IDLE && next_step == ST_IDLE) begin
      done = 1'b1;
      next_addr = IDLE_ADDR;
      next_rw = 1'b1;
      next_cycle = 3'h0;
    end
    if (illegal) begin
      next_step = ST_IDLE;
      next_group = G_NONE;
      done = 1'b1;
      next_addr = IDLE_ADDR;
      next_rw = 1'b1;
      next_cycle = 3'h0;
    end
  end

  // state registers only
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      step <= ST_IDLE;
      group <= G_NONE;
      addr <= IDLE_ADDR;
      rw <= 1'b1;
      dout <= 8'h00;
      cycle <= 3'h0;
      fetch <= 16'h0000;
      eff <= 16'h0000;
      offset <= 8'h00;
      x_base <= 16'h0000;
      sp <= 16'h0000;
      store_word <= 16'h0000;
      store_byte <= 8'h00;
      opcode <= 8'h00;
      page <= 8'h00;
      operand <= 16'h0000;
      mask <= 8'h00;
      branch <= 8'h00;
      target_opc <= 8'h00;
      target <= 16'h0000;
    end else begin
      step <= next_step;
      group <= next_group;
      addr <= next_addr;
      rw <= next_rw;
      dout <= next_dout;
      cycle <= next_cycle;
      fetch <= next_fetch;
      eff <= next_eff;
      offset <= next_offset;
      x_base <= next_x_base;
      sp <= next_sp;
      store_word <= next_store_word;
      store_byte <= next_store_byte;
      opcode <= next_opcode;
      page <= next_page;
      operand <= next_operand;
      mask <= next_mask;
      branch <= next_branch;
      target_opc <= next_target_opc;
      target <= next_target;
    end
  end

  // outputs; DONE and ILLEGAL mark the last bus cycle
  assign ADDR = addr;
  assign RW = rw;
  assign DATA_OUT = dout;
  assign BUSY = (step != ST_IDLE);
  assign DONE = done;
  assign ILLEGAL = illegal;
  assign STEP = step;
  assign GROUP = group;
  assign CYCLE_NUM = cycle;
  assign OPCODE = opcode;
  assign PAGE_OPCODE = page;
  assign OPERAND_WORD = operand;
  assign MASK_BYTE = mask;
  assign BRANCH_BYTE = branch;
  assign TARGET_OPCODE = target_opc;
  assign TARGET_ADDR = target;
  assign NEXT_PC = fetch;

endmodule

// [test/ixbcs_chk.sv]
/*
  Assertion checker for the indexed-X bus-cycle sequencer.
  Assumes it is bound to the sequencer and sees only its ports.
*/
`timescale 1ns/1ns
module ixbcs_chk
  import ixbcs_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // start request
  input wire logic START,
  input wire logic [15:0] PC_IN,
  // bus and status
  input wire logic [15:0] ADDR,
  input wire logic RW,
  input wire logic BUSY,
  input wire logic DONE,
  input wire ixbcs_step_t STEP,
  input wire ixbcs_group_t GROUP,
  input wire logic [2:0] CYCLE_NUM
);
  // one clock domain, so clocking and disable are set once
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  // a start taken while idle puts the opcode address out at once
  start_taken_a: assert property (
    START && !BUSY |=> BUSY && RW && ADDR == $past(PC_IN)
      && CYCLE_NUM == 3'h1) else $error("start not taken");
  offset_next_a: assert property (
    STEP == ST_OFFSET |-> RW && ADDR == $past(ADDR) + 16'h0001)
    else $error("offset fetch address wrong");
  dummy_read_a: assert property (
    STEP == ST_DUMMY |-> RW && ADDR == 16'hFFFF)
    else $error("dummy read not at FFFF");
  jump_len_a: assert property (
    GROUP == G_JUMP && CYCLE_NUM == 3'h3 |-> DONE && ADDR == 16'hFFFF)
    else $error("jump length wrong");
  // write-back lands on the address read two cycles before
  modify_wb_a: assert property (
    GROUP == G_MODIFY && STEP == ST_OPND |=> RW && ADDR == 16'hFFFF
      ##1 !RW && DONE && ADDR == $past(ADDR, 2))
    else $error("modify write-back wrong");
  test_ro_a: assert property (
    GROUP == G_TEST && BUSY |-> RW) else $error("test wrote memory");
  word_lo_a: assert property (
    STEP == ST_OPND_LO |-> ADDR == $past(ADDR) + 16'h0001)
    else $error("low byte address wrong");
  push_pair_a: assert property (
    STEP == ST_PUSH_LO |-> !RW ##1 !RW && DONE
      && ADDR == $past(ADDR) - 16'h0001) else $error("push order wrong");
  cmp_tail_a: assert property (
    GROUP == G_EXT_CMP && CYCLE_NUM == 3'h7 |-> DONE && RW
      && ADDR == 16'hFFFF) else $error("compare tail wrong");
endmodule

bind ixbcs_sequencer ixbcs_chk i_chk (.CLOCK(CLOCK), .RST(RST),
  .START(START), .PC_IN(PC_IN), .ADDR(ADDR), .RW(RW), .BUSY(BUSY),
  .DONE(DONE), .STEP(STEP), .GROUP(GROUP), .CYCLE_NUM(CYCLE_NUM));

// [test/ixbcs_mem_model.sv]
/*
  Program and data memory on the sequencer's bus.
  Assumes a same-clock bus: reads answer within the cycle.
*/
`timescale 1ns/1ns
module ixbcs_mem_model (
  // bus clock
  input wire logic CLOCK,
  // bus from the sequencer
  input wire logic [15:0] ADDR,
  input wire logic RW,
  input wire logic [7:0] DATA_OUT,
  // read data back
  output logic [7:0] DATA_IN
);
  logic [7:0] mem [0:65535];
  // address-derived fill so an unset byte rarely looks right
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
    end
  end
  // no drive while writing: show the inverse, never the old byte
  assign DATA_IN = RW ? mem[ADDR] : ~DATA_OUT;
  // write lands at the edge that closes the cycle
  always @(posedge CLOCK) begin
    if (!RW) begin
      mem[ADDR] <= DATA_OUT;
    end
  end
endmodule

// [test/tb_top.sv]
/*
  Self-checking bench for the indexed-X bus-cycle sequencer.
  Assumes the memory model answers reads in the same cycle.
*/
`timescale 1ns/1ns
`define CHK(nm, ex, ac) \
  begin checked++; if ((ac) !== (ex)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, ex, ac); end end
module tb_top;
  localparam logic [15:0] PA = 16'h4000; // program address
  localparam logic [15:0] EA = 16'h0010; // FFF0 plus 20 wraps
  localparam logic [15:0] SP = 16'h01FF;
  logic clock = 0, rst = 1, start = 0;
  logic [15:0] pc_in = 0, x_in = 16'hFFF0, sp_in = SP;
  logic [15:0] store_word = 16'hBEEF;
  logic [7:0] store_byte = 8'h5A, result_byte = 8'hC3;
  logic [15:0] addr, operand_word, target_addr, next_pc;
  logic [7:0] data_out, data_in, target_opcode;
  logic [7:0] opcode, page_opcode, mask_byte, branch_byte;
  logic rw, busy, done, illegal;
  logic bad = 0; // set while a scenario expects a refused opcode
  logic [15:0] ea [1:7];
  logic er [1:7];
  int n_mismatch = 0;
  int checked = 0;

  ixbcs_sequencer i_dut (.CLOCK(clock), .RST(rst), .START(start),
    .PC_IN(pc_in), .X_IN(x_in), .SP_IN(sp_in), .STORE_WORD(store_word),
    .STORE_BYTE(store_byte), .RESULT_BYTE(result_byte), .ADDR(addr),
    .RW(rw), .DATA_OUT(data_out), .DATA_IN(data_in), .BUSY(busy),
    .DONE(done), .ILLEGAL(illegal), .STEP(), .GROUP(), .CYCLE_NUM(),
    .OPCODE(opcode), .PAGE_OPCODE(page_opcode),
    .OPERAND_WORD(operand_word), .MASK_BYTE(mask_byte),
    .BRANCH_BYTE(branch_byte), .TARGET_OPCODE(target_opcode),
    .TARGET_ADDR(target_addr), .NEXT_PC(next_pc));
  ixbcs_mem_model i_mem (.CLOCK(clock), .ADDR(addr), .RW(rw),
    .DATA_OUT(data_out), .DATA_IN(data_in));

  always #25 clock = ~clock;

  task automatic e(input int k, input logic [15:0] a, input logic r);
    ea[k] = a;
    er[k] = r;
  endtask
  // one-byte opcode: opcode, offset, dummy
  task automatic pre1();
    e(1, PA, 1); e(2, PA + 1, 1); e(3, 16'hFFFF, 1);
    i_mem.mem[PA + 1] = 8'h20;
  endtask
  // prefixed: prefix, second byte, offset, dummy
  task automatic pre2(input logic [7:0] op2);
    e(1, PA, 1); e(2, PA + 1, 1); e(3, PA + 2, 1); e(4, 16'hFFFF, 1);
    i_mem.mem[PA + 1] = op2;
    i_mem.mem[PA + 2] = 8'h20;
  endtask
  // run one instruction and compare every bus cycle
  task automatic go(input logic [7:0] op, input int n);
    i_mem.mem[PA] = op;
    @(posedge clock);
    start <= 1'b1;
    pc_in <= PA;
    @(posedge clock);
    start <= 1'b0;
    for (int k = 1; k <= n; k++) begin
      #1;
      `CHK("addr", ea[k], addr)
      `CHK("rw", er[k], rw)
      `CHK("done", 1'(k == n), done)
      `CHK("illegal", 1'(bad && k == n), illegal)
      @(posedge clock);
    end
    #1;
    `CHK("busy", 1'b0, busy)
    $display("done: opcode %h", op);
  endtask

  task automatic t_byte();
    pre1(); e(4, EA, 1); i_mem.mem[EA] = 8'h96;
    go(8'h6E, 3);
    `CHK("jmp_tgt", EA, target_addr)
    `CHK("jmp_pc", 16'h4002, next_pc)
    go(8'hA6, 4);
    `CHK("opnd", 8'h96, operand_word[7:0])
    e(4, EA, 0);
    go(8'hA7, 4);
    `CHK("store", 8'h5A, i_mem.mem[EA])
    e(4, EA, 1); e(5, 16'hFFFF, 1); e(6, 16'hFFFF, 1);
    go(8'h6D, 6);
    `CHK("tested", 8'h5A, i_mem.mem[EA])
    e(6, EA, 0);
    go(8'h6C, 6);
    `CHK("modify", 8'hC3, i_mem.mem[EA])
  endtask

  task automatic t_word();
    logic [7:0] ops [3] = '{8'hEC, 8'hAE, 8'hEE};
    logic [7:0] sts [3] = '{8'hED, 8'hAF, 8'hEF};
    logic [7:0] ars [3] = '{8'hA3, 8'hE3, 8'hAC};
    for (int i = 0; i < 3; i++) begin
      pre1(); e(4, EA, 1); e(5, EA + 1, 1);
      i_mem.mem[EA] = 8'h12; i_mem.mem[EA + 1] = 8'h34;
      go(ops[i], 5);
      `CHK("load", 16'h1234, operand_word)
      e(6, 16'hFFFF, 1);
      go(ars[i], 6);
      e(4, EA, 0); e(5, EA + 1, 0); i_mem.mem[EA] = 8'h00;
      go(sts[i], 5);
      `CHK("st_hi", 8'hBE, i_mem.mem[EA])
      `CHK("st_lo", 8'hEF, i_mem.mem[EA + 1])
    end
  endtask

  task automatic t_prefixed();
    pre2(8'hEE); e(5, EA, 1); e(6, EA + 1, 1);
    i_mem.mem[EA] = 8'hA5; i_mem.mem[EA + 1] = 8'h5A;
    go(8'h1A, 6);
    `CHK("load_y", 16'hA55A, operand_word)
    `CHK("prefix", 8'h1A, opcode)
    `CHK("page_op", 8'hEE, page_opcode)
    e(7, 16'hFFFF, 1);
    pre2(8'hA3); go(8'h1A, 7);
    pre2(8'hAC); go(8'h1A, 7);
    pre2(8'hEF); e(5, EA, 0); e(6, EA + 1, 0);
    go(8'h1A, 6);
    `CHK("sty_hi", 8'hBE, i_mem.mem[EA])
    `CHK("sty_lo", 8'hEF, i_mem.mem[EA + 1])
    e(1, PA, 1); e(2, PA + 1, 1); e(3, PA + 2, 1); e(4, PA + 3, 1);
    e(5, 16'h3000, 1); e(6, 16'h3001, 1);
    i_mem.mem[PA + 2] = 8'h30; i_mem.mem[PA + 3] = 8'h00;
    i_mem.mem[16'h3000] = 8'h9C; i_mem.mem[16'h3001] = 8'h3E;
    i_mem.mem[PA + 1] = 8'hB3; go(8'h1A, 7);
    `CHK("ext_cmp", 16'h9C3E, operand_word)
    i_mem.mem[PA + 1] = 8'hBC; go(8'h18, 7);
  endtask

  task automatic t_bits_calls();
    for (int i = 0; i < 2; i++) begin
      pre1(); e(4, EA, 1); e(5, PA + 2, 1); e(6, 16'hFFFF, 1);
      e(7, EA, 0); i_mem.mem[EA] = 8'h00;
      i_mem.mem[PA + 2] = 8'h81;
      go(8'h1C + 8'(i), 7);
      `CHK("bit_op", 8'hC3, i_mem.mem[EA])
      `CHK("mask", 8'h81, mask_byte)
      e(6, PA + 3, 1); e(7, 16'hFFFF, 1);
      i_mem.mem[PA + 2] = 8'h42;
      i_mem.mem[PA + 3] = 8'h7E;
      go(8'h1E + 8'(i), 7);
      `CHK("br_mask", 8'h42, mask_byte)
      `CHK("br_off", 8'h7E, branch_byte)
    end
    pre1(); e(4, EA, 1); e(5, SP, 0); e(6, SP - 1, 0);
    i_mem.mem[EA] = 8'h77;
    go(8'hAD, 6);
    `CHK("tgt_op", 8'h77, target_opcode)
    `CHK("ret_lo", 8'h02, i_mem.mem[SP])
    `CHK("ret_hi", 8'h40, i_mem.mem[SP - 1])
    e(2, PA + 1, 1); e(3, PA + 2, 1); e(4, 16'h5000, 1);
    i_mem.mem[PA + 1] = 8'h50; i_mem.mem[PA + 2] = 8'h00;
    i_mem.mem[16'h5000] = 8'h3D;
    // clear the high slot so a missing push cannot pass on old data
    i_mem.mem[SP - 1] = 8'h00;
    go(8'hBD, 6);
    `CHK("ext_tgt", 8'h3D, target_opcode)
    `CHK("ext_addr", 16'h5000, target_addr)
    `CHK("ret_pc", 16'h4003, next_pc)
    `CHK("ext_lo", 8'h03, i_mem.mem[SP])
    `CHK("ext_hi", 8'h40, i_mem.mem[SP - 1])
  endtask

  // undecodable first byte, then undecodable byte behind a prefix
  task automatic t_illegal();
    bad = 1'b1;
    e(1, PA, 1);
    go(8'h01, 1);
    e(2, PA + 1, 1);
    i_mem.mem[PA + 1] = 8'h01;
    go(8'h1A, 2);
    bad = 1'b0;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_byte();
    t_word();
    t_prefixed();
    t_bits_calls();
    t_illegal();
    end_sim();
  end
  // about 230 cycles expected; cut a hang well after that
  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end
endmodule
